/* core/event_capture.sv */
// Four-input event capture and pulse counter with AXI4-Lite registers
//
// Contract
// - Four inputs, each with own settings, selected by index 0 to 3.
// - Mode codes: 0 off, 1 strobe default, 2 count, 3 same as 1.
// - Strobe captures receiver time at chosen edge; polarity 0 falling default.
// - Strobe captures throttled to at most 200 Hz; not in count mode.
// - Count mode totals pulses per second, reported and restarted at PPS.
// - Signed ns bias -999..999, default 0, added to strobe times only.
// - Strobe rejects pulses closer than guard ms after last accepted one.
`include "event_capture_params.svh"
module event_capture
  import event_capture_pkg::*;
#(
  parameter int SECOND   = `SECOND_CYCLES,
  parameter int THROTTLE = `THROTTLE_CYCLES,
  parameter int MS       = `MS_CYCLES
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic [3:0]  event_pins_in,
  input  wire logic        pps_pin_in,
  input  wire logic [11:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [11:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic             irq_out
);
  logic [1:0]        mode     [4];
  logic [3:0]        polarity;
  logic signed [10:0] bias    [4];
  logic [15:0]       guard    [4];
  logic [63:0]       capture  [4];
  logic [3:0]        strobe;
  logic [31:0]       total    [4];
  logic [3:0]        total_valid;
  logic [7:0]        status;
  logic [7:0]        mask;
  logic [63:0]       now_ns;
  logic [31:0]       sec_tick;
  logic              pps_a;
  logic              pps_b;
  logic              pps_last;
  logic [1:0]        sel;
  logic [11:0]       aw_addr;
  logic              aw_held;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic              w_held;
  bus_state_t        rd_state;

  ////////////////////////////////////////////////////////////////////////////
  // Receiver time in ns, 1 PPS synchronised from the pin
  wire pps_pulse = pps_b & ~pps_last;
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pps_a    <= 1'b0;
      pps_b    <= 1'b0;
      pps_last <= 1'b0;
      now_ns   <= 64'h0;
      sec_tick <= 32'h0;
    end
    else
    begin
      pps_a    <= pps_pin_in;
      pps_b    <= pps_a;
      pps_last <= pps_b;
      now_ns   <= now_ns + 64'(`NS_PER_CLK);
      sec_tick <= (pps_pulse || sec_tick == 32'(SECOND - 1)) ? 32'h0 : sec_tick + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-input channels
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : ch
      event_channel #(
        .THROTTLE (THROTTLE),
        .MS       (MS)
      ) u_ch (
        .clk_sys_in      (clk_sys_in),
        .reset_in        (reset_in),
        .pin_in          (event_pins_in[g]),
        .mode_in         (mode[g]),
        .polarity_in     (polarity[g]),
        .guard_ms_in     (guard[g]),
        .pps_in          (pps_pulse),
        .strobe_out      (strobe[g]),
        .count_out       (total[g]),
        .count_valid_out (total_valid[g])
      );
      // Edge is two sync stages plus one register behind; bias applied here
      always_ff @(posedge clk_sys_in or posedge reset_in)
      begin
        if (reset_in)
          capture[g] <= 64'h0;
        else if (strobe[g])
          capture[g] <= now_ns + 64'(signed'(bias[g]));
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order
  wire        do_write   = aw_held & w_held & ~s_axi_bvalid_out;
  wire        cfg_hit    = do_write && aw_addr == `OFS_CONFIG && w_data[`CFG_WRITE_BIT];
  wire [1:0]  w_index    = w_data[`CFG_INDEX_LSB +: 2];
  wire [1:0]  w_mode     = w_data[`CFG_MODE_LSB +: 2];
  wire signed [31:0] w_bias = signed'(w_data);
  wire        bias_ok    = (w_bias >= -32'sd999) && (w_bias <= 32'sd999);
  wire        bias_hit   = do_write && aw_addr == `OFS_BIAS;
  wire        guard_hit  = do_write && aw_addr == `OFS_GUARD;
  wire        mask_hit   = do_write && aw_addr == `OFS_MASK;
  wire        sel_hit    = do_write && aw_addr == `OFS_CONFIG;
  wire        w_known    = sel_hit | guard_hit | mask_hit | (bias_hit & bias_ok);
  wire [7:0]  events     = {total_valid, strobe};

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      aw_held           <= 1'b0;
      w_held            <= 1'b0;
      aw_addr           <= 12'h0;
      w_data            <= 32'h0;
      w_strb            <= 4'h0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid_in && s_axi_awready_out)
      begin
        aw_addr           <= s_axi_awaddr_in;
        aw_held           <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out)
      begin
        w_data           <= s_axi_wdata_in;
        w_strb           <= s_axi_wstrb_in;
        w_held           <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write)
      begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= w_known ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid_out && s_axi_bready_in)
      begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Settings of the selected input and the shared event mask; byte strobes ignored, whole-word writes
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sel      <= 2'h0;
      polarity <= {4{`POL_RESET}};
      mask     <= 8'h0;
      for (int i = 0; i < 4; i++)
      begin
        mode[i]  <= `MODE_RESET;
        bias[i]  <= `BIAS_RESET;
        guard[i] <= `GUARD_RESET;
      end
    end
    else
    begin
      if (sel_hit)
        sel <= w_index;
      if (cfg_hit)
      begin
        mode[w_index]     <= w_mode;
        polarity[w_index] <= w_data[`CFG_POL_BIT];
      end
      if (bias_hit && bias_ok)
        bias[sel] <= w_bias[10:0];
      if (guard_hit)
        guard[sel] <= w_data[15:0];
      if (mask_hit)
        mask <= w_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel and sticky status
  wire [11:0] ra       = s_axi_araddr_in;
  wire        ra_cap   = ra[11:6] == 6'h1 && ra[2:0] == 3'h0;
  wire        ra_cnt   = ra[11:4] == 8'h08 && ra[1:0] == 2'h0;
  wire [1:0]  ra_ch    = ra_cap ? ra[5:4] : ra[3:2];
  wire        rd_take  = s_axi_arvalid_in & s_axi_arready_out;
  wire        st_read  = rd_take && ra == `OFS_STATUS;
  logic [31:0] rd_word;
  logic        rd_ok;

  always_comb
  begin
    rd_ok   = 1'b1;
    rd_word = 32'h0;
    if (ra_cap && ra[3] == 1'b0)
      rd_word = capture[ra_ch][31:0];
    else if (ra_cap)
      rd_word = capture[ra_ch][63:32];
    else if (ra_cnt)
      rd_word = total[ra_ch];
    else
    begin
      case (ra)
        `OFS_CONFIG: rd_word = {23'h0, polarity[sel], 2'h0, mode[sel], 2'h0, sel};
        `OFS_BIAS:   rd_word = 32'(signed'(bias[sel]));
        `OFS_GUARD:  rd_word = {16'h0, guard[sel]};
        `OFS_STATUS: rd_word = {24'h0, status};
        `OFS_MASK:   rd_word = {24'h0, mask};
        `OFS_NOW_LO: rd_word = now_ns[31:0];
        `OFS_NOW_HI: rd_word = now_ns[63:32];
        default:     rd_ok   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      rd_state          <= ST_IDLE;
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= 2'h0;
      status            <= 8'h0;
      irq_out           <= 1'b0;
    end
    else
    begin
      // New events win over the clear of a status read
      status  <= (st_read ? 8'h0 : status) | events;
      irq_out <= |(((st_read ? 8'h0 : status) | events) & mask);
      case (rd_state)
        ST_IDLE:
        begin
          if (rd_take)
          begin
            s_axi_rdata_out   <= rd_ok ? rd_word : 32'h0;
            s_axi_rresp_out   <= rd_ok ? 2'h0 : 2'h2;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_arready_out <= 1'b0;
            rd_state          <= ST_RESP;
          end
        end
        ST_RESP:
        begin
          if (s_axi_rready_in)
          begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
            rd_state          <= ST_IDLE;
          end
        end
        default:
          rd_state <= ST_IDLE;
      endcase
    end
  end
endmodule : event_capture

/* core/event_channel.sv */
// One event input: synchroniser, edge select, guard, throttle and pulse counter
`include "event_capture_params.svh"
module event_channel
  import event_capture_pkg::*;
#(
  parameter int THROTTLE = `THROTTLE_CYCLES,
  parameter int MS       = `MS_CYCLES
)
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        pin_in,
  input  wire logic [1:0]  mode_in,
  input  wire logic        polarity_in,
  input  wire logic [15:0] guard_ms_in,
  input  wire logic        pps_in,
  output logic             strobe_out,
  output logic [31:0]      count_out,
  output logic             count_valid_out
);
  logic        sync_a;
  logic        sync_b;
  logic        last;
  logic [31:0] accum;
  logic [22:0] throttle_left;
  logic [15:0] ms_left;
  logic [31:0] ms_tick;
  logic [2:0]  warm;
  // Edges ignored until the chain holds the pin: an idle-high pin would look like a rise
  wire         rise        = sync_b & ~last & warm[2];
  wire         fall        = ~sync_b & last & warm[2];
  wire         edge_seen   = polarity_in ? rise : fall;
  wire         strobe_mode = (mode_in == MODE_STROBE) || (mode_in == MODE_ALIAS);
  wire         count_mode  = (mode_in == MODE_COUNT);
  wire         ready       = (throttle_left == 23'h0) && (ms_left == 16'h0);
  wire         accept      = strobe_mode & edge_seen & ready;
  wire         ms_wrap     = (ms_tick == 32'(MS - 1));

  // Two stages before the edge detector
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      last   <= 1'b0;
      warm   <= 3'h0;
    end
    else
    begin
      sync_a <= pin_in;
      sync_b <= sync_a;
      last   <= sync_b;
      warm   <= {warm[1:0], 1'b1};
    end
  end

  // Guard in ms and 200 Hz throttle both run from the accepted edge
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      throttle_left <= 23'h0;
      ms_left       <= 16'h0;
      ms_tick       <= 32'h0;
      strobe_out    <= 1'b0;
    end
    else
    begin
      strobe_out <= accept;
      ms_tick    <= (accept || ms_wrap) ? 32'h0 : ms_tick + 32'h1;
      if (accept)
      begin
        throttle_left <= 23'(THROTTLE - 1);
        ms_left       <= guard_ms_in;
      end
      else
      begin
        if (throttle_left != 23'h0)
          throttle_left <= throttle_left - 23'h1;
        if (ms_wrap && ms_left != 16'h0)
          ms_left <= ms_left - 16'h1;
      end
    end
  end

  // Counting ignores guard and throttle; total latched on each PPS
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      accum           <= 32'h0;
      count_out       <= 32'h0;
      count_valid_out <= 1'b0;
    end
    else
    begin
      count_valid_out <= pps_in & count_mode;
      if (pps_in)
      begin
        count_out <= accum + {31'h0, count_mode & edge_seen};
        accum     <= 32'h0;
      end
      else if (count_mode && edge_seen)
        accum <= accum + 32'h1;
    end
  end
endmodule : event_channel

/* shared/event_capture_params.svh */
// Offsets, field positions, reset values and timing counts of the event capture block
`ifndef EVENT_CAPTURE_PARAMS_SVH
`define EVENT_CAPTURE_PARAMS_SVH
`define OFS_CONFIG        12'h000
`define OFS_BIAS          12'h004
`define OFS_GUARD         12'h008
`define OFS_STATUS        12'h00c
`define OFS_MASK          12'h010
`define OFS_TIME_LO       12'h014
`define OFS_TIME_HI       12'h018
`define OFS_NOW_LO        12'h01c
`define OFS_NOW_HI        12'h020
`define OFS_CAPTURE_BASE  12'h040
`define OFS_COUNT_BASE    12'h080
`define CFG_INDEX_LSB     0
`define CFG_MODE_LSB      4
`define CFG_POL_BIT       8
`define CFG_WRITE_BIT     31
`define MODE_RESET        2'h1
`define POL_RESET         1'b0
`define BIAS_RESET        11'h000
`define GUARD_RESET       16'h0004
`define CLK_HZ            40000000
`define NS_PER_CLK        25
`define THROTTLE_HZ       200
`define THROTTLE_CYCLES   (`CLK_HZ / `THROTTLE_HZ)
`define MS_CYCLES         (`CLK_HZ / 1000)
`define SECOND_CYCLES     `CLK_HZ
`endif

/* shared/event_capture_pkg.sv */
// Types shared by the event capture block
package event_capture_pkg;
  typedef enum logic [1:0]
  {
    MODE_OFF    = 2'h0,
    MODE_STROBE = 2'h1,
    MODE_COUNT  = 2'h2,
    MODE_ALIAS  = 2'h3
  } input_mode_t;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_DATA  = 3'b010,
    ST_RESP  = 3'b100
  } bus_state_t;
endpackage : event_capture_pkg

/* testbench/event_capture_props.sv */
// Bus handshake checks at the event capture register port
`include "event_capture_params.svh"
module event_capture_props
(
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic [1:0]  s_axi_rresp_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        s_axi_rready_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bias word outside the signed ns window
  wire bias_bad = ($signed(s_axi_wdata_in) > 32'sd999) ||
                  ($signed(s_axi_wdata_in) < -32'sd999);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////////////////////////////
  sequence wr_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
  endsequence
  sequence b_answer;
    !s_axi_awready_out ##1 s_axi_bvalid_out;
  endsequence
  sequence ar_take;
    s_axi_arvalid_in && s_axi_arready_out;
  endsequence
  ////////////////////////////////////////////////////////////////
  AST_B_LATENCY: assert property (wr_take |=> b_answer)
    else $error("write answer late");
  AST_R_LATENCY: assert property (ar_take |=> s_axi_rvalid_out)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("bresp dropped");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rresp_out))
    else $error("rresp dropped");
  AST_B_DONE: assert property (s_axi_bvalid_out && s_axi_bready_in
    |=> !s_axi_bvalid_out && s_axi_awready_out)
    else $error("write not closed");
  AST_R_DONE: assert property (s_axi_rvalid_out && s_axi_rready_in
    |=> !s_axi_rvalid_out && s_axi_arready_out)
    else $error("read not closed");
  AST_AR_REFUSE: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted early");
  AST_UNMAPPED: assert property (ar_take ##0 s_axi_araddr_in == 12'hffc
    |=> s_axi_rresp_out == 2'h2)
    else $error("unmapped read okay");
  AST_BIAS_RANGE: assert property (wr_take ##0 s_axi_awaddr_in == `OFS_BIAS
    |=> ##1 s_axi_bresp_out == ($past(bias_bad, 2) ? 2'h2 : 2'h0))
    else $error("bias range answer wrong");
endmodule : event_capture_props

bind event_capture event_capture_props u_props (.*);

/* testbench/event_capture_test.sv */
// Register-level test of the four-input event capture block
`include "event_capture_params.svh"
module event_capture_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in;
  logic        reset_in;
  logic [3:0]  pins;
  logic        pps;
  logic [11:0] awa;
  logic [11:0] ara;
  logic [3:0]  ws;
  logic [31:0] wd;
  logic [31:0] rdt;
  logic [31:0] v;
  logic [31:0] w;
  logic [1:0]  br;
  logic [1:0]  rr;
  logic        awv, awr, wv, wrd, bv, brd, arv, arr, rv, rrd, irq;
  int          n_errors = 0;
  int          checks = 0;
  logic [31:0] cfg [4] = '{32'h10, 32'h131, 32'h12, 32'h123};
  logic [31:0] bias [4] = '{32'h64, 32'hffffffce, 32'h0, 32'h0};
  logic [31:0] guard [4] = '{32'h0, 32'h0, 32'ha, 32'h0};
  event_capture #(.THROTTLE(50), .MS(10)) uut
  (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in), .event_pins_in(pins),
    .pps_pin_in(pps), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(br),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(brd), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdt),
    .s_axi_rresp_out(rr), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd),
    .irq_out(irq)
  );
  event_source src (.clk_sys_in(clk_sys_in), .pins_out(pins), .pps_out(pps));
  ////////////////////////////////////////////////////////////////
  task end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task write_reg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] e);
    bit done;
    done = 1'b0;
    @(posedge clk_sys_in);
    awa <= a;
    wd <= d;
    ws <= 4'hf;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(posedge clk_sys_in);
      if (awr)
        awv <= 1'b0;
      if (wrd)
        wv <= 1'b0;
      if (bv)
      begin
        brd <= 1'b0;
        done = 1'b1;
        check({30'h0, br}, {30'h0, e});
      end
    end
    // A hung bus ends the run here
    if (!done)
    begin
      n_errors++;
      end_sim();
    end
  endtask : write_reg
  task read_reg(input logic [11:0] a, input logic [1:0] e, output logic [31:0] d);
    bit done;
    done = 1'b0;
    @(posedge clk_sys_in);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    for (int i = 0; i < 100 && !done; i++)
    begin
      @(posedge clk_sys_in);
      if (arr)
        arv <= 1'b0;
      if (rv)
      begin
        rrd <= 1'b0;
        done = 1'b1;
        d = rdt;
        check({30'h0, rr}, {30'h0, e});
      end
    end
    if (!done)
    begin
      n_errors++;
      end_sim();
    end
  endtask : read_reg
  task rchk(input logic [11:0] a, input logic [31:0] exp);
    read_reg(a, 2'h0, v);
    check(v, exp);
  endtask : rchk
  // Capture lands four clocks after the edge; ten leaves margin
  task chk_status(input logic [31:0] s, input logic q);
    repeat (10) @(posedge clk_sys_in);
    check({31'h0, irq}, {31'h0, q});
    rchk(`OFS_STATUS, s);
  endtask : chk_status
  task gap_pulse(input logic [3:0] m);
    repeat (60) @(posedge clk_sys_in);
    src.pulse(m);
  endtask : gap_pulse
  ////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    reset_in = 1'b1;
    {awa, ara, wd, ws} = '0;
    {awv, wv, brd, arv, rrd} = '0;
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    rchk(`OFS_CONFIG, 32'h10);
    rchk(`OFS_GUARD, 32'h4);
    rchk(`OFS_BIAS, 32'h0);
    read_reg(12'hffc, 2'h2, v);
    check(v, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      write_reg(`OFS_CONFIG, 32'h80000000 | cfg[i], 2'h0);
      write_reg(`OFS_BIAS, bias[i], 2'h0);
      write_reg(`OFS_GUARD, guard[i], 2'h0);
      rchk(`OFS_CONFIG, cfg[i]);
    end
    write_reg(`OFS_BIAS, 32'h3e8, 2'h2);
    rchk(`OFS_BIAS, 32'h0);
    write_reg(`OFS_MASK, 32'h2, 2'h0);
    // Line 0 falls while line 1 rises
    src.flip(4'h3);
    chk_status(32'h3, 1'b1);
    rchk(`OFS_STATUS, 32'h0);
    check({31'h0, irq}, 32'h0);
    read_reg(`OFS_CAPTURE_BASE, 2'h0, v);
    read_reg(`OFS_CAPTURE_BASE + 12'h10, 2'h0, w);
    check(v - w, 32'h96);
    repeat (60) @(posedge clk_sys_in);
    src.flip(4'h3);
    chk_status(32'h0, 1'b0);
    repeat (60) @(posedge clk_sys_in);
    src.flip(4'h1);
    chk_status(32'h1, 1'b0);
    src.pulse(4'h1);
    chk_status(32'h0, 1'b0);
    gap_pulse(4'h1);
    chk_status(32'h1, 1'b0);
    // Second edge clears throttle but not the guard
    src.flip(4'h4);
    chk_status(32'h4, 1'b0);
    gap_pulse(4'h4);
    chk_status(32'h0, 1'b0);
    gap_pulse(4'h4);
    chk_status(32'h4, 1'b0);
    write_reg(`OFS_CONFIG, 32'h80000002, 2'h0);
    gap_pulse(4'h4);
    chk_status(32'h0, 1'b0);
    repeat (5) src.pulse(4'h8);
    src.second();
    chk_status(32'h80, 1'b0);
    rchk(`OFS_COUNT_BASE + 12'hc, 32'h5);
    repeat (3) src.pulse(4'h8);
    src.second();
    chk_status(32'h80, 1'b0);
    rchk(`OFS_COUNT_BASE + 12'hc, 32'h3);
    end_sim();
  end
endmodule : event_capture_test

/* testbench/event_source.sv */
// External trigger sources driving the event lines and second pulse
module event_source
(
  input  wire logic       clk_sys_in,
  output logic      [3:0] pins_out,
  output logic            pps_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Lines 0 and 2 idle high, 1 and 3 idle low
  initial
  begin
    pins_out = 4'h5;
    pps_out = 1'b0;
  end
  task flip(input logic [3:0] m);
    @(posedge clk_sys_in);
    pins_out <= pins_out ^ m;
  endtask : flip
  task pulse(input logic [3:0] m);
    flip(m);
    repeat (2) @(posedge clk_sys_in);
    pins_out <= pins_out ^ m;
  endtask : pulse
  task second();
    @(posedge clk_sys_in);
    pps_out <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    pps_out <= 1'b0;
  endtask : second
endmodule : event_source
